// ### design/ida_data_mem.sv
// Byte wide data memory with a registered read port.
// Assumes one core clock; read and write never come in the same cycle.
`timescale 1ns/1ps
module ida_data_mem (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic [11:0] addr_i,
   input wire logic we_i,
   input wire logic [7:0] wdata_i,
   input wire logic rd_i,
   input wire logic byp_en_i,
   input wire logic [7:0] byp_data_i,
   output logic [7:0] rdata_o
);

   // ************************************************************
   // Storage
   // ************************************************************
   // No reset on the array: contents are undefined after reset
   logic [7:0] mem [0:ida_pkg::MEM_DEPTH-1];

   // Write port
   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   // Read register; bypass lets register values share the one output flop
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= ida_pkg::RDATA_RESET;
      end else if (ce_i && rd_i) begin
         rdata_o <= byp_en_i ? byp_data_i : mem[addr_i];
      end
   end

endmodule // ida_data_mem

// ### design/ida_indirect.sv
// Indirect data addressing: three pointers, their access locations and
// the working register, in front of the core's data memory.
// Assumes the core issues one-cycle read or write strobes, never both.
//
// What this block does
// - Plain location accesses pointed byte, pointer kept
// - Post-increment: use pointer, then add one
// - Post-decrement: use pointer, then subtract one
// - Pre-increment: add one, then use new pointer
// - Offset location addresses pointer plus working register
// - Pointer is low byte plus four-bit high
`timescale 1ns/1ps
module ida_indirect (
   input wire logic CLOCK_I,
   input wire logic RST_N_I,
   input wire logic CE_I,
   input wire logic [11:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O
);

   // ************************************************************
   // Decoding functions
   // ************************************************************

   // Kind of access an address selects
   function automatic ida_pkg::ida_kind_t decode_kind(
      input logic [11:0] addr
   );
      ida_pkg::ida_kind_t kind;
      kind = ida_pkg::IDA_KIND_DIRECT;
      if (addr == ida_pkg::WORK_OFF) begin
         kind = ida_pkg::IDA_KIND_WORK;
      end
      for (int i = 0; i < ida_pkg::NUM_PTR; i++) begin
         if (addr == ida_pkg::PLAIN_OFF[i]) begin
            kind = ida_pkg::IDA_KIND_PLAIN;
         end
         if (addr == ida_pkg::POSTINC_OFF[i]) begin
            kind = ida_pkg::IDA_KIND_POSTINC;
         end
         if (addr == ida_pkg::POSTDEC_OFF[i]) begin
            kind = ida_pkg::IDA_KIND_POSTDEC;
         end
         if (addr == ida_pkg::PREINC_OFF[i]) begin
            kind = ida_pkg::IDA_KIND_PREINC;
         end
         if (addr == ida_pkg::OFFSET_OFF[i]) begin
            kind = ida_pkg::IDA_KIND_OFFSET;
         end
         if (addr == ida_pkg::HIGH_OFF[i]) begin
            kind = ida_pkg::IDA_KIND_HIGH;
         end
         if (addr == ida_pkg::LOW_OFF[i]) begin
            kind = ida_pkg::IDA_KIND_LOW;
         end
      end
      return kind;
   endfunction

   // Pointer that an address belongs to; zero when none
   function automatic logic [1:0] decode_ptr(input logic [11:0] addr);
      logic [1:0] sel;
      sel = 2'h0;
      for (int i = 0; i < ida_pkg::NUM_PTR; i++) begin
         if (addr == ida_pkg::PLAIN_OFF[i] ||
             addr == ida_pkg::POSTINC_OFF[i] ||
             addr == ida_pkg::POSTDEC_OFF[i] ||
             addr == ida_pkg::PREINC_OFF[i] ||
             addr == ida_pkg::OFFSET_OFF[i] ||
             addr == ida_pkg::HIGH_OFF[i] ||
             addr == ida_pkg::LOW_OFF[i]) begin
            sel = i[1:0];
         end
      end
      return sel;
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   logic [11:0] ptr_q [0:2]; // Pointers, high part in bits 11:8
   logic [7:0] work_q; // Working register

   // ************************************************************
   // Access decode
   // ************************************************************
   logic acc; // Any strobe this cycle
   ida_pkg::ida_kind_t kind; // Decoded access kind
   logic [1:0] sel; // Selected pointer
   logic [11:0] cur_ptr; // Value of the selected pointer
   logic [11:0] ptr_inc; // Selected pointer plus one
   logic [11:0] ptr_dec; // Selected pointer minus one
   logic [11:0] work_sext; // Working register sign extended
   logic [11:0] ptr_offs; // Selected pointer plus signed offset

   assign acc = WR_I | RD_I;
   assign kind = decode_kind(ADDR_I);
   assign sel = decode_ptr(ADDR_I);
   assign cur_ptr = ptr_q[sel];

   // Twelve-bit adders carry across low and high parts and wrap
   assign ptr_inc = cur_ptr + ida_pkg::PTR_STEP;
   assign ptr_dec = cur_ptr - ida_pkg::PTR_STEP;
   // Signed offset reaches from 128 bytes below to 127 bytes above the pointer
   assign work_sext = {{4{work_q[7]}}, work_q};
   assign ptr_offs = cur_ptr + work_sext;

   // ************************************************************
   // Effective address and memory control
   // ************************************************************
   logic [11:0] mem_addr; // Address presented to data memory
   logic mem_we; // Data memory write
   logic byp_en; // Read returns a register, not memory
   logic [7:0] byp_data; // Register value for a read

   // Effective address per access kind
   always_comb begin
      case (kind)
         ida_pkg::IDA_KIND_PLAIN: begin
            mem_addr = cur_ptr;
         end
         ida_pkg::IDA_KIND_POSTINC: begin
            mem_addr = cur_ptr;
         end
         ida_pkg::IDA_KIND_POSTDEC: begin
            mem_addr = cur_ptr;
         end
         ida_pkg::IDA_KIND_PREINC: begin
            mem_addr = ptr_inc;
         end
         ida_pkg::IDA_KIND_OFFSET: begin
            mem_addr = ptr_offs;
         end
         default: begin
            mem_addr = ADDR_I; // Direct access
         end
      endcase
   end

   // Register locations never reach memory; access locations do
   always_comb begin
      case (kind)
         ida_pkg::IDA_KIND_LOW: begin
            byp_en = 1'b1;
            byp_data = cur_ptr[7:0];
         end
         ida_pkg::IDA_KIND_HIGH: begin
            byp_en = 1'b1;
            byp_data = {ida_pkg::HIGH_PAD, cur_ptr[11:8]};
         end
         ida_pkg::IDA_KIND_WORK: begin
            byp_en = 1'b1;
            byp_data = work_q;
         end
         default: begin
            byp_en = 1'b0;
            byp_data = ida_pkg::RDATA_RESET;
         end
      endcase
   end

   // Access locations hold no storage; writes land in memory
   assign mem_we = WR_I & ~byp_en;

   // ************************************************************
   // Data memory
   // ************************************************************
   ida_data_mem u_mem (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .ce_i(CE_I),
      .addr_i(mem_addr),
      .we_i(mem_we),
      .wdata_i(WDATA_I),
      .rd_i(RD_I),
      .byp_en_i(byp_en),
      .byp_data_i(byp_data),
      .rdata_o(RDATA_O)
   );

   // ************************************************************
   // Working register
   // ************************************************************
   always_ff @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         work_q <= ida_pkg::WORK_RESET;
      end else if (CE_I && WR_I && kind == ida_pkg::IDA_KIND_WORK) begin
         work_q <= WDATA_I;
      end
   end

   // ************************************************************
   // Pointers
   // ************************************************************
   // One update process per pointer; only the selected one moves
   for (genvar g = 0; g < ida_pkg::NUM_PTR; g++) begin : g_ptr
      logic hit; // Strobe with this pointer selected; pointer 0 also on any address outside the pointer map
      assign hit = acc && (sel == 2'(g));

      always_ff @(posedge CLOCK_I) begin
         if (!RST_N_I) begin
            ptr_q[g] <= ida_pkg::PTR_RESET;
         end else if (CE_I && hit) begin
            case (kind)
               ida_pkg::IDA_KIND_POSTINC: begin
                  ptr_q[g] <= ptr_inc;
               end
               ida_pkg::IDA_KIND_PREINC: begin
                  ptr_q[g] <= ptr_inc;
               end
               ida_pkg::IDA_KIND_POSTDEC: begin
                  ptr_q[g] <= ptr_dec;
               end
               ida_pkg::IDA_KIND_LOW: begin
                  if (WR_I) begin
                     ptr_q[g][7:0] <= WDATA_I;
                  end
               end
               ida_pkg::IDA_KIND_HIGH: begin
                  // Upper four written bits are dropped
                  if (WR_I) begin
                     ptr_q[g][11:8] <= WDATA_I[3:0];
                  end
               end
               default: begin
                  // Plain and offset leave the pointer alone
                  ptr_q[g] <= ptr_q[g];
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   logic step_acc; // Enabled access this cycle
   assign step_acc = CE_I && acc;
   // An attempt cut short by reset is dropped, not judged; a short
   // reset pulse in the middle of a step therefore goes unchecked

   // Plain access addresses the pointer and keeps it
   AST_PLAIN_KEEP:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (step_acc && kind == ida_pkg::IDA_KIND_PLAIN)
      |-> (mem_addr == cur_ptr) ##1 (ptr_q[$past(sel)] == $past(cur_ptr)))
   else $error("plain access moved pointer or used wrong address");

   // Post-increment uses old value, then steps up
   AST_POSTINC:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (step_acc && kind == ida_pkg::IDA_KIND_POSTINC)
      |-> (mem_addr == cur_ptr)
      ##1 (ptr_q[$past(sel)] == $past(cur_ptr) + 12'h001))
   else $error("post-increment access wrong");

   // Post-decrement uses old value, then steps down
   AST_POSTDEC:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (step_acc && kind == ida_pkg::IDA_KIND_POSTDEC)
      |-> (mem_addr == cur_ptr)
      ##1 (ptr_q[$past(sel)] == $past(cur_ptr) - 12'h001))
   else $error("post-decrement access wrong");

   // Pre-increment addresses the stepped value, which is kept
   AST_PREINC:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (step_acc && kind == ida_pkg::IDA_KIND_PREINC)
      |-> (mem_addr == cur_ptr + 12'h001)
      ##1 (ptr_q[$past(sel)] == $past(mem_addr)))
   else $error("pre-increment access wrong");

   // Offset access adds the signed working register, pointer kept
   AST_OFFSET:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (step_acc && kind == ida_pkg::IDA_KIND_OFFSET)
      |-> (mem_addr == cur_ptr + {{4{work_q[7]}}, work_q})
      ##1 (ptr_q[$past(sel)] == $past(cur_ptr)))
   else $error("offset access wrong");

   // High register reads back with upper bits clear
   AST_HIGH_READ:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (CE_I && RD_I && kind == ida_pkg::IDA_KIND_HIGH)
      |=> (RDATA_O == {4'h0, $past(cur_ptr[11:8])}))
   else $error("high register read wrong");

   // Increment of the top address wraps to zero
   AST_WRAP:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (step_acc && kind == ida_pkg::IDA_KIND_POSTINC
       && cur_ptr == 12'hfff)
      |=> (ptr_q[$past(sel)] == 12'h000))
   else $error("pointer did not wrap");

   // Low byte borrow reaches the high part
   AST_BORROW:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (step_acc && kind == ida_pkg::IDA_KIND_POSTDEC
       && cur_ptr[7:0] == 8'h00 && cur_ptr[11:8] != 4'h0)
      |=> (ptr_q[$past(sel)][11:8] == $past(cur_ptr[11:8]) - 4'h1))
   else $error("borrow not carried into high part");

   // Low byte carry reaches the high part
   AST_CARRY:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (step_acc && kind == ida_pkg::IDA_KIND_POSTINC
       && cur_ptr[7:0] == 8'hff && cur_ptr[11:8] != 4'hf)
      |=> (ptr_q[$past(sel)][11:8] == $past(cur_ptr[11:8]) + 4'h1))
   else $error("carry not taken into high part");

   // Low register reads back the pointer's low byte
   AST_LOW_READ:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (CE_I && RD_I && kind == ida_pkg::IDA_KIND_LOW)
      |=> (RDATA_O == $past(cur_ptr[7:0])))
   else $error("low register read wrong");

   // High register write keeps only the four implemented bits
   AST_HIGH_WRITE:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (CE_I && WR_I && kind == ida_pkg::IDA_KIND_HIGH)
      |=> (ptr_q[$past(sel)][11:8] == $past(WDATA_I[3:0])))
   else $error("high register write wrong");

   // Working register takes written data, offset follows it
   AST_WORK_WRITE:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      (CE_I && WR_I && kind == ida_pkg::IDA_KIND_WORK)
      |=> (work_q == $past(WDATA_I)))
   else $error("working register write lost");

   // Enable low freezes pointers, working register and read data
   AST_FREEZE:
   assert property (@(posedge CLOCK_I) disable iff (!RST_N_I)
      !CE_I |=> ($stable(work_q) && $stable(RDATA_O)
      && $stable(ptr_q[0]) && $stable(ptr_q[1]) && $stable(ptr_q[2])))
   else $error("state moved while enable low");

endmodule // ida_indirect

// ### design/ida_pkg.sv
// Constants shared by the indirect addressing block and its data memory.
// Assumes one core clock; the register port addresses a 12-bit space.
package ida_pkg;

   // ************************************************************
   // Widths
   // ************************************************************
   localparam int ADDR_W = 12; // Data memory address width
   localparam int DATA_W = 8; // Byte wide data path
   localparam int HIGH_W = 4; // Implemented bits of a high register
   localparam int NUM_PTR = 3; // Number of indirect pointers
   localparam int MEM_DEPTH = 4096; // Bytes of data memory

   // ************************************************************
   // Register offsets, one entry per pointer, one for the working register
   // ************************************************************
   localparam logic [11:0] PLAIN_OFF [0:2] = '{12'hfef, 12'hfe7, 12'hfdf};
   localparam logic [11:0] POSTINC_OFF [0:2] = '{12'hfee, 12'hfe6, 12'hfde};
   localparam logic [11:0] POSTDEC_OFF [0:2] = '{12'hfed, 12'hfe5, 12'hfdd};
   localparam logic [11:0] PREINC_OFF [0:2] = '{12'hfec, 12'hfe4, 12'hfdc};
   localparam logic [11:0] OFFSET_OFF [0:2] = '{12'hfeb, 12'hfe3, 12'hfdb};
   localparam logic [11:0] HIGH_OFF [0:2] = '{12'hfea, 12'hfe2, 12'hfda};
   localparam logic [11:0] LOW_OFF [0:2] = '{12'hfe9, 12'hfe1, 12'hfd9};
   localparam logic [11:0] WORK_OFF = 12'hfe8; // Working register

   // ************************************************************
   // Reset values and steps
   // ************************************************************
   localparam logic [11:0] PTR_RESET = 12'h000; // Pointers after reset
   localparam logic [7:0] WORK_RESET = 8'h00; // Working reg after reset
   localparam logic [7:0] RDATA_RESET = 8'h00; // Read data after reset
   localparam logic [11:0] PTR_STEP = 12'h001; // Increment or decrement
   localparam logic [3:0] HIGH_PAD = 4'h0; // Unimplemented high bits

   // ************************************************************
   // Access kinds decoded from an address
   // ************************************************************
   typedef enum logic [3:0] {
      IDA_KIND_DIRECT = 4'h0, // Plain data memory location
      IDA_KIND_PLAIN = 4'h1,
      IDA_KIND_POSTINC = 4'h2,
      IDA_KIND_POSTDEC = 4'h3,
      IDA_KIND_PREINC = 4'h4,
      IDA_KIND_OFFSET = 4'h5,
      IDA_KIND_LOW = 4'h6,
      IDA_KIND_HIGH = 4'h7,
      IDA_KIND_WORK = 4'h8
   } ida_kind_t;

endpackage

// ### verification/ida_core_model.sv
// Core-side bus master model that drives the indirect addressing block.
// Assumes one core clock; each wr or rd call issues exactly one request.
`timescale 1ns/1ps
module ida_core_model (
   input wire logic clk_i,
   output logic ce_o,
   output logic [11:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [7:0] rdata_i
);
   // ****************
   // Bus cycles
   // ****************
   // Quiet bus from time zero
   initial begin
      ce_o = 1'b0;
      addr_o = 12'h000;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // Write: strobe left up, so writes can run back to back
   task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic c);
      @(posedge clk_i);
      ce_o <= c;
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      rd_o <= 1'b0;
   endtask

   // Read: data is taken only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, input logic c,
      output logic [7:0] d);
      @(posedge clk_i);
      ce_o <= c;
      addr_o <= a;
      wr_o <= 1'b0;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      // Stale write data is scrambled so it cannot be reused
      wdata_o <= ~wdata_o;
      #1 d = rdata_i;
   endtask

   // Drop every strobe
   task automatic idle();
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      wdata_o <= ~wdata_o;
   endtask
endmodule // ida_core_model

// ### verification/indirect_data_addressing_bench.sv
// Self-checking bench: random and corner accesses against a byte model.
// Assumes the core model drives every bus input of the design.
`timescale 1ns/1ps
module indirect_data_addressing_bench;
   localparam int LIMIT = 40000; // Cycle ceiling, run needs about 9k
   logic clk;
   logic rst_n;
   logic ce;
   logic [11:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   int n_fail = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [11:0] ptr [0:2]; // Expected pointers
   logic [7:0] work; // Expected working register
   logic [7:0] last_rd; // Read data holds between reads
   logic [7:0] mem [0:4095]; // Expected memory
   logic [11:0] a;
   logic [31:0] seed;

   ida_indirect i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .CE_I(ce),
      .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata));
   ida_core_model i_core (.clk_i(clk), .ce_o(ce), .addr_o(addr),
      .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

   // ****************
   // Clock and watchdog
   // ****************
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // A hang counts as a failure
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         n_fail++;
         stop_test();
      end
   end

   // ****************
   // Expectation and checks
   // ****************
   // Applies one access to the model, returns the expected read byte
   function automatic logic [7:0] access(input logic [11:0] x,
      input logic we, input logic [7:0] d);
      logic [11:0] ea;
      logic [7:0] r;
      logic m;
      ea = x;
      r = 8'h00;
      m = 1'b1;
      for (int p = 0; p < 3; p++) begin
         case (x)
            ida_pkg::PLAIN_OFF[p]: ea = ptr[p];
            ida_pkg::POSTINC_OFF[p]: begin
               ea = ptr[p];
               ptr[p] = ptr[p] + 12'h001;
            end
            ida_pkg::POSTDEC_OFF[p]: begin
               ea = ptr[p];
               ptr[p] = ptr[p] - 12'h001;
            end
            ida_pkg::PREINC_OFF[p]: begin
               ptr[p] = ptr[p] + 12'h001;
               ea = ptr[p];
            end
            ida_pkg::OFFSET_OFF[p]: ea = ptr[p] + {{4{work[7]}}, work};
            ida_pkg::LOW_OFF[p]: begin
               m = 1'b0;
               r = ptr[p][7:0];
               if (we) ptr[p][7:0] = d;
            end
            ida_pkg::HIGH_OFF[p]: begin
               m = 1'b0;
               r = {4'h0, ptr[p][11:8]};
               if (we) ptr[p][11:8] = d[3:0];
            end
            default: ;
         endcase
      end
      if (x == ida_pkg::WORK_OFF) begin
         m = 1'b0;
         r = work;
         if (we) work = d;
      end
      // Anything outside the map is a plain memory byte
      if (m) begin
         r = mem[ea];
         if (we) mem[ea] = d;
      end
      return r;
   endfunction

   task automatic check(input logic [11:0] x, input logic [7:0] s,
      input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH addr %h expected %h seen %h", x, e, s);
      end
   endtask

   // One bus request; with the enable low nothing may change
   task automatic op(input logic [11:0] x, input logic we,
      input logic [7:0] d, input logic c);
      logic [7:0] e;
      logic [7:0] s;
      if (we) i_core.wr(x, d, c);
      else i_core.rd(x, c, s);
      e = c ? access(x, we, d) : last_rd;
      if (!we) begin
         last_rd = e;
         check(x, s, e);
      end
   endtask

   // Reset for eight cycles; memory keeps no defined value
   task automatic do_reset();
      i_core.idle();
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      ptr = '{12'h000, 12'h000, 12'h000};
      work = 8'h00;
      last_rd = 8'h00;
      #1 check(12'h000, rdata, 8'h00);
   endtask

   task automatic stop_test();
      if (n_fail == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ****************
   // Main sequence
   // ****************
   initial begin
      rst_n = 1'b0;
      seed = $urandom(32'h2154);
      do_reset();
      // Fill all memory through one stepping pointer, wrapping once
      repeat (4096) op(ida_pkg::POSTINC_OFF[0], 1'b1, 8'($urandom), 1'b1);
      // Carry, borrow, wrap, pad bits, signed offset, enable low
      for (int p = 0; p < 3; p++) begin
         op(ida_pkg::LOW_OFF[p], 1'b1, 8'hff, 1'b1);
         op(ida_pkg::HIGH_OFF[p], 1'b1, 8'h00, 1'b1);
         op(ida_pkg::POSTINC_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::HIGH_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::LOW_OFF[p], 1'b1, 8'h00, 1'b1);
         op(ida_pkg::HIGH_OFF[p], 1'b1, 8'h00, 1'b1);
         op(ida_pkg::POSTDEC_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::HIGH_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::PREINC_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::LOW_OFF[p], 1'b0, 8'h00, 1'b1);
         // Borrow out of a zero low byte into a nonzero high part
         op(ida_pkg::HIGH_OFF[p], 1'b1, 8'h05, 1'b1);
         op(ida_pkg::POSTDEC_OFF[p], 1'b1, 8'h77, 1'b1);
         op(ida_pkg::HIGH_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::POSTINC_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::HIGH_OFF[p], 1'b1, 8'hff, 1'b1);
         op(ida_pkg::HIGH_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::WORK_OFF, 1'b1, 8'h80, 1'b1);
         op(ida_pkg::OFFSET_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::LOW_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::PLAIN_OFF[p], 1'b1, 8'h5a, 1'b1);
         op(ida_pkg::PLAIN_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::POSTINC_OFF[p], 1'b1, 8'h33, 1'b0);
         op(ida_pkg::LOW_OFF[p], 1'b0, 8'h00, 1'b0);
         op(ida_pkg::LOW_OFF[p], 1'b0, 8'h00, 1'b1);
      end
      // Random mix over the map and the whole address space
      for (int i = 0; i < 3000; i++) begin
         a = ($urandom % 2) ? 12'hfd8 + 12'($urandom % 24) : 12'($urandom);
         op(a, 1'($urandom), 8'($urandom), ($urandom % 8) != 0);
      end
      // Second reset in mid-run clears pointers and working register
      do_reset();
      for (int p = 0; p < 3; p++) begin
         op(ida_pkg::LOW_OFF[p], 1'b0, 8'h00, 1'b1);
         op(ida_pkg::HIGH_OFF[p], 1'b0, 8'h00, 1'b1);
      end
      op(ida_pkg::WORK_OFF, 1'b0, 8'h00, 1'b1);
      stop_test();
   end
endmodule // indirect_data_addressing_bench
